// file: hdl/wdt_regs.svh
// Purpose: Constants for the windowed watchdog timer
// Assumes: 125 MHz core clock
// Notes:   Fields, reset values and timing counts
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

`define WDT_CTRL_RESET       8'h7f
`define WDT_ACT_BIT          7
`define WDT_TOP_BIT          6
`define WDT_PRESCALE_CYCLES  16000
`define WDT_PRESCALE_WIDTH   14
`define WDT_RST_PULSE_NS     30000
`define WDT_CLK_PERIOD_NS    8
`define WDT_RST_PULSE_CYCLES ((`WDT_RST_PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)
`define WDT_PULSE_WIDTH      12

`endif

// file: hdl/wdt_pkg.sv
// Purpose: Types for the windowed watchdog timer
// Assumes: Nothing beyond the constants header
// Notes:   Control word layout as a packed struct
package wdt_pkg;
	typedef struct packed {
		logic       watchdog_activate;
		logic [6:0] count;
	} wd_control_reg_t;

	typedef struct packed {
		logic hw_watchdog;
		logic halt_reset_option;
	} wd_options_t;

	typedef enum logic [1:0] {IDLE, PULSE} rst_state_t;
endpackage

// file: hdl/wdt_prescaler.sv
// Purpose: Free-running tick divider for the watchdog count
// Assumes: Synchronous active-high reset
// Notes:   Never cleared by control writes
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_prescaler #(
	parameter int DIVIDE = `WDT_PRESCALE_CYCLES,
	parameter int WIDTH  = `WDT_PRESCALE_WIDTH
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// Tick
	output logic      tick_o
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_tick;

	always_comb begin
		if (count == WIDTH'(DIVIDE - 1)) begin
			next_count = '0;
			next_tick  = 1'b1;
		end else begin
			next_count = count + 1'b1;
			next_tick  = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			count  <= '0;
			tick_o <= 1'b0;
		end else begin
			count  <= next_count;
			tick_o <= next_tick;
		end
	end
endmodule
`default_nettype wire

// file: hdl/windowed_watchdog_timer.sv
// Purpose: Software-refreshed watchdog with a 7-bit downcounter
// Assumes: Option straps stable; write strobe is one cycle, same clock
// Notes:   Only output toward the chip is the reset request
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

// Function
// - Count steps down by one every 16000 clock cycles via prescaler.
// - Active and count falls 40h to 3Fh: pulse reset about 30 us.
// - Counter decrements always; activation only gates the reset.
// - After reset the watchdog is inactive unless the hardware option is set.
// - Software cannot clear the activation bit once set.
// - Write with activation set and top count bit clear forces reset.
// - Active watchdog turns HALT into a reset unless option disables it.
// - Option selects whether HALT resets; disabled means HALT proceeds.
// - Hardware option makes watchdog always active, ignoring activation bit.
// - Timeout programmable in 64 prescaled steps.
// - Control writes leave the prescaler running untouched.
// - Control: activation bit 7, count bits 6:0, reset 7Fh.
// - Activation set only by software, cleared only by reset.
module windowed_watchdog_timer #(
	parameter int PRESCALE    = `WDT_PRESCALE_CYCLES,
	parameter int PULSE_TICKS = `WDT_RST_PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	// Control register access
	input  wire logic                     ctrl_write_i,
	input  wire logic [7:0]               ctrl_wdata_i,
	output logic      [7:0]               ctrl_rdata_o,
	// Option straps (pins, synchronised here)
	input  wire logic                     hw_watchdog_i,
	input  wire logic                     halt_reset_option_i,
	// CPU halt request
	input  wire logic                     halt_request_i,
	output logic                          halt_grant_o,
	// Reset request toward the chip, active low
	output logic                          reset_request_n_o
);
	// ******************************************
	// Option synchronisers
	// ******************************************
	wdt_pkg::wd_options_t opt_meta;
	wdt_pkg::wd_options_t opt;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			opt_meta <= '0;
			opt      <= '0;
		end else begin
			opt_meta <= {hw_watchdog_i, halt_reset_option_i};
			opt      <= opt_meta;
		end
	end

	// ******************************************
	// Prescaler
	// ******************************************
	logic tick;

	// No write input: reload timing jitters by up to one tick period
	wdt_prescaler #(
		.DIVIDE (PRESCALE),
		.WIDTH  (`WDT_PRESCALE_WIDTH)
	) u_prescaler (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.tick_o  (tick)
	);

	// ******************************************
	// Control register and counter
	// ******************************************
	wdt_pkg::wd_control_reg_t wd_control_reg;
	wdt_pkg::wd_control_reg_t next_wd_control_reg;
	wdt_pkg::wd_control_reg_t wr;
	logic                     active;
	logic                     expire;

	assign wr     = wdt_pkg::wd_control_reg_t'(ctrl_wdata_i);
	assign active = wd_control_reg.watchdog_activate | opt.hw_watchdog;

	always_comb begin
		next_wd_control_reg = wd_control_reg;
		expire              = 1'b0;
		if (ctrl_write_i) begin
			// Load wins over a tick in the same cycle
			next_wd_control_reg.count = wr.count;
			// Sticky: a write can set but never clear
			next_wd_control_reg.watchdog_activate =
				wd_control_reg.watchdog_activate | wr.watchdog_activate;
			// Forced reset: written value already below the window
			expire = (wr.watchdog_activate | active) & ~wr.count[6];
		end else if (tick) begin
			next_wd_control_reg.count = wd_control_reg.count - 7'h01;
			expire = active && wd_control_reg.count == 7'h40;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wd_control_reg <= `WDT_CTRL_RESET;
		end else begin
			wd_control_reg <= next_wd_control_reg;
		end
	end

	assign ctrl_rdata_o = wd_control_reg;

	// ******************************************
	// HALT handling
	// ******************************************
	logic halt_reset;

	assign halt_reset   = halt_request_i & active & ~opt.halt_reset_option;
	assign halt_grant_o = halt_request_i & ~halt_reset;

	// ******************************************
	// Reset pulse generator
	// ******************************************
	// Pulse keeps running once started; chip reset will usually follow
	wdt_pkg::rst_state_t          state;
	wdt_pkg::rst_state_t          next_state;
	logic [`WDT_PULSE_WIDTH-1:0]  pulse_cnt;
	logic [`WDT_PULSE_WIDTH-1:0]  next_pulse_cnt;
	logic                         next_reset_request_n;

	always_comb begin
		next_state           = state;
		next_pulse_cnt       = pulse_cnt;
		next_reset_request_n = 1'b1;
		unique case (state)
			wdt_pkg::IDLE: begin
				if (expire | halt_reset) begin
					next_state           = wdt_pkg::PULSE;
					next_pulse_cnt       = `WDT_PULSE_WIDTH'(PULSE_TICKS - 1);
					next_reset_request_n = 1'b0;
				end
			end
			wdt_pkg::PULSE: begin
				if (pulse_cnt == '0) begin
					next_state = wdt_pkg::IDLE;
				end else begin
					next_pulse_cnt       = pulse_cnt - 1'b1;
					next_reset_request_n = 1'b0;
				end
			end
			default: begin
				next_state = wdt_pkg::IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state             <= wdt_pkg::IDLE;
			pulse_cnt         <= '0;
			reset_request_n_o <= 1'b1;
		end else begin
			state             <= next_state;
			pulse_cnt         <= next_pulse_cnt;
			reset_request_n_o <= next_reset_request_n;
		end
	end

	// ******************************************
	// Assertions
	// ******************************************
	// Length of the current low stretch on the reset request
	logic [`WDT_PULSE_WIDTH-1:0] low_run;
	logic [`WDT_PULSE_WIDTH-1:0] next_low_run;

	always_comb begin
		next_low_run = '0;
		if (!reset_request_n_o) begin
			next_low_run = low_run + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			low_run <= '0;
		end else begin
			low_run <= next_low_run;
		end
	end

	sequence expiry_seq;
		active && tick && !ctrl_write_i && wd_control_reg.count == 7'h40 &&
			state == wdt_pkg::IDLE;
	endsequence

	expiry_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
		expiry_seq |=> !reset_request_n_o)
		else $error("expiry did not assert reset");

	pulse_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(reset_request_n_o) |-> !reset_request_n_o [*8])
		else $error("reset pulse too short");

	pulse_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!reset_request_n_o |-> low_run < PULSE_TICKS)
		else $error("reset pulse too long");

	free_count_a: assert property (@(posedge clk_i) disable iff (reset_i)
		tick && !ctrl_write_i |=> wd_control_reg.count == $past(wd_control_reg.count) - 7'h01)
		else $error("counter did not step");

	no_tick_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!tick && !ctrl_write_i |=> $stable(wd_control_reg.count))
		else $error("counter moved without tick");

	reset_value_a: assert property (@(posedge clk_i)
		reset_i |=> wd_control_reg == 8'h7f)
		else $error("control reset value wrong");

	act_sticky_a: assert property (@(posedge clk_i) disable iff (reset_i)
		wd_control_reg.watchdog_activate |=> wd_control_reg.watchdog_activate)
		else $error("activation bit cleared");

	load_count_a: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_write_i |=> wd_control_reg.count == $past(ctrl_wdata_i[6:0]))
		else $error("write did not load counter");

	soft_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_write_i && ctrl_wdata_i[7] && !ctrl_wdata_i[6] && state == wdt_pkg::IDLE
		|=> !reset_request_n_o)
		else $error("forced reset missing");

	halt_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
		halt_request_i && active && !opt.halt_reset_option
		|-> !halt_grant_o ##1 (!reset_request_n_o || $past(state) == wdt_pkg::PULSE))
		else $error("halt not turned into reset");

	halt_pass_a: assert property (@(posedge clk_i) disable iff (reset_i)
		halt_request_i && opt.halt_reset_option |-> halt_grant_o)
		else $error("halt blocked with option set");

	hw_active_a: assert property (@(posedge clk_i) disable iff (reset_i)
		opt.hw_watchdog && !wd_control_reg.watchdog_activate && tick && !ctrl_write_i &&
			wd_control_reg.count == 7'h40 && state == wdt_pkg::IDLE
		|=> !reset_request_n_o)
		else $error("hardware watchdog not active");
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Self-checking bench for the windowed watchdog timer
// Assumes: Short prescale (8) and reset pulse (10) counts
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none

module testbench;
	// ********************
	// Signals
	// ********************
	logic       clk_i               = 1'b0;
	logic       reset_i             = 1'b1;
	logic       ctrl_write_i        = 1'b0;
	logic [7:0] ctrl_wdata_i        = 8'h00;
	logic       hw_watchdog_i       = 1'b0;
	logic       halt_reset_option_i = 1'b0;
	logic       halt_request_i      = 1'b0;
	logic [7:0] ctrl_rdata_o;
	logic       halt_grant_o;
	logic       reset_request_n_o;
	logic       saw_low;
	int         n_errors            = 0;
	int         checks_done         = 0;
	int         n;

	always #4 clk_i = ~clk_i;

	windowed_watchdog_timer #(.PRESCALE(8), .PULSE_TICKS(10)) dut (
		.clk_i               (clk_i),
		.reset_i             (reset_i),
		.ctrl_write_i        (ctrl_write_i),
		.ctrl_wdata_i        (ctrl_wdata_i),
		.ctrl_rdata_o        (ctrl_rdata_o),
		.hw_watchdog_i       (hw_watchdog_i),
		.halt_reset_option_i (halt_reset_option_i),
		.halt_request_i      (halt_request_i),
		.halt_grant_o        (halt_grant_o),
		.reset_request_n_o   (reset_request_n_o)
	);

	// ********************
	// Tasks
	// ********************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Straps need two edges after release to pass the synchroniser
	task automatic do_reset(input logic hw, input logic hopt);
		@(negedge clk_i);
		hw_watchdog_i = hw;
		halt_reset_option_i = hopt;
		reset_i = 1'b1;
		repeat (10) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (2) @(negedge clk_i);
	endtask

	// Caller leaves one edge between two writes
	task automatic wr(input logic [7:0] d);
		ctrl_write_i = 1'b1;
		ctrl_wdata_i = d;
		@(negedge clk_i);
		ctrl_write_i = 1'b0;
	endtask

	task automatic wait_val(input logic [7:0] exp, input int max);
		n = 0;
		while (ctrl_rdata_o !== exp) begin
			if (reset_request_n_o === 1'b0) saw_low = 1'b1;
			n++;
			if (n > max) begin
				n_errors++;
				finish_test();
			end
			@(negedge clk_i);
		end
	endtask

	// Waits for the reset request, then measures its length
	task automatic wait_pulse(input int max);
		n = 0;
		while (reset_request_n_o !== 1'b0) begin
			n++;
			if (n > max) begin
				n_errors++;
				finish_test();
			end
			@(negedge clk_i);
		end
		n = 0;
		while (reset_request_n_o === 1'b0 && n < 20) begin
			n++;
			@(negedge clk_i);
		end
		check(8'(n), 8'h0a);
	endtask

	// ********************
	// Sequence
	// ********************
	initial begin
		do_reset(1'b0, 1'b0);
		check(ctrl_rdata_o, 8'h7f);
		check(reset_request_n_o, 1'b1);
		halt_request_i = 1'b1;
		#1 check(halt_grant_o, 1'b1);
		@(negedge clk_i);
		halt_request_i = 1'b0;
		wr(8'h41);
		saw_low = 1'b0;
		wait_val(8'h40, 20);
		// Prescaler phase survives the write: first step comes early
		check(8'(n), 8'h05);
		wait_val(8'h3f, 20);
		check(8'(n), 8'h08);
		check({saw_low, reset_request_n_o}, 8'h01);
		wr(8'h00);
		check(reset_request_n_o, 1'b1);
		@(negedge clk_i);
		wr(8'hc2);
		check(ctrl_rdata_o, 8'hc2);
		@(negedge clk_i);
		wr(8'h45);
		check(ctrl_rdata_o, 8'hc5);
		wait_pulse(60);
		// Forced reset by a write with the top count bit clear
		do_reset(1'b0, 1'b0);
		wr(8'h80);
		check(reset_request_n_o, 1'b0);
		wait_pulse(1);
		// Halt while active turns into a reset
		do_reset(1'b0, 1'b0);
		wr(8'hff);
		halt_request_i = 1'b1;
		#1 check(halt_grant_o, 1'b0);
		wait_pulse(3);
		halt_request_i = 1'b0;
		// Halt option set: halt is granted, no reset
		do_reset(1'b0, 1'b1);
		wr(8'hff);
		halt_request_i = 1'b1;
		#1 check(halt_grant_o, 1'b1);
		repeat (4) @(negedge clk_i);
		check(reset_request_n_o, 1'b1);
		halt_request_i = 1'b0;
		// Hardware strap: rollover resets without the activation bit
		do_reset(1'b1, 1'b0);
		wr(8'h41);
		check(ctrl_rdata_o, 8'h41);
		wait_pulse(40);
		finish_test();
	end
endmodule

`default_nettype wire
